// [hdl/in_sync.sv]
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module in_sync #(
  parameter int WIDTH = 7
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] stage_one;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stage_one <= '0;
      pin_sync <= '0;
    end else begin
      stage_one <= pin_in;
      pin_sync <= stage_one;
    end
  end
endmodule : in_sync

// [hdl/output_state_alarm_signal_ctrl.sv]
// output-state and alarm-signalling control with an APB register file
// How it works
// R1: remote permission off: digital commands and standby input are ignored
// R2: remote disallowed: control location reads as local
// R3: polarity bit inverts standby input level and its function
// R4: off-only action: standby input can only switch output off
// R5: auto action: standby toggles off/on, on only if enabled elsewhere
// R6: pin 1 ORs overtemperature and power-fail, each enable separate
// R7: pin 2 ORs overvoltage, overcurrent, overpower; default overvoltage only
// R8: pin 3 shows constant voltage mode, or output-on when selected
// R9: overtemperature recovery off: stages stay off after cooling
// R10: overtemperature recovery auto: restore pre-alarm state after cooling
// R11: power-up off: output starts off
// R12: power-up restore: output takes state held before switch-off
// R13: power-fail recovery off: output stays off until user acts
// R14: power-fail recovery auto: output back on if it was on before
// R15: any power-fail switches output off at once
// R16: overvoltage, overcurrent, overpower each switch output off
// R17: overtemperature switches power stages off while it lasts
// R18: alarm pins are registered OR of enabled alarms
// R19: output state kept in a retained register for restore
`timescale 1ns/1ps
`include "output_state_defines.svh"
module output_state_alarm_signal_ctrl (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire output_state_pkg::alarm_in_t alarm_in,
  input wire logic remote_standby_input,
  input wire logic retained_output_on,
  output logic retained_output_store,
  output logic dc_output_on,
  output logic power_stage_on,
  output logic remote_active,
  output output_state_pkg::status_pins_t status_pins,
  output logic irq
);
  import output_state_pkg::*;

  // ----------------------------------------
  // input synchronisation
  // ----------------------------------------
  logic [6:0] sync_raw;
  logic [6:0] sync_out;
  alarm_in_t alarms;
  logic standby_level;
  logic standby_prev;
  assign sync_raw = {alarm_in, remote_standby_input};
  in_sync #(.WIDTH(7)) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin_in(sync_raw),
    .pin_sync(sync_out)
  );
  assign alarms = alarm_in_t'(sync_out[6:1]);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] control;
  logic [31:0] pin_select;
  logic [`EVT_WIDTH-1:0] event_flags;
  logic [`EVT_WIDTH-1:0] event_mask;
  logic [`EVT_WIDTH-1:0] event_set;
  logic wr_access;
  logic rd_access;
  logic cmd_on;
  logic cmd_off;
  logic remote_ok;
  logic addr_ok;

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == `REG_CONTROL) || (a == `REG_PIN_SELECT) || (a == `REG_STATUS) ||
                 (a == `REG_EVENT) || (a == `REG_MASK) || (a == `REG_COMMAND);
  endfunction : known_addr

  assign addr_ok = known_addr(paddr);
  assign wr_access = psel && penable && pwrite && pready;
  assign rd_access = psel && !penable && !pwrite;
  assign remote_ok = control[`CTL_REMOTE_ALLOW];
  assign cmd_on = wr_access && paddr == `REG_COMMAND && pwdata[`CMD_OUTPUT_ON] && remote_ok; // [R1]
  assign cmd_off = wr_access && paddr == `REG_COMMAND && pwdata[`CMD_OUTPUT_OFF] && remote_ok; // [R1]

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      control <= `CTL_RESET;
      pin_select <= `SEL_RESET; // [R6] [R7] [R8]
      event_mask <= '0;
    end else if (wr_access) begin
      if (paddr == `REG_CONTROL) begin
        control <= pwdata;
      end else if (paddr == `REG_PIN_SELECT) begin
        pin_select <= pwdata;
      end else if (paddr == `REG_MASK) begin
        event_mask <= pwdata[`EVT_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------
  // apb answer: no wait state, pready in the first access cycle
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // ----------------------------------------
  // standby input: polarity and action
  // ----------------------------------------
  logic sb_active;
  logic sb_off_edge;
  logic sb_on_edge;
  logic sb_held_off;
  logic enabled_elsewhere;
  assign standby_level = sync_out[0] ^ control[`CTL_SB_INVERT]; // [R3]
  assign sb_active = standby_level && remote_ok; // [R1]
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      standby_prev <= 1'b0;
    end else begin
      standby_prev <= sb_active;
    end
  end
  assign sb_off_edge = sb_active && !standby_prev;
  assign sb_on_edge = !sb_active && standby_prev && control[`CTL_SB_AUTO]; // [R4] [R5]

  // ----------------------------------------
  // output state machine
  // ----------------------------------------
  out_state_t state;
  logic trip_protect;
  logic pre_alarm_on;
  assign trip_protect = alarms.overvoltage_alarm || alarms.overcurrent_alarm ||
                        alarms.overpower_alarm; // [R16]

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= ST_BOOT;
      dc_output_on <= 1'b0;
      power_stage_on <= 1'b0;
      pre_alarm_on <= 1'b0;
      enabled_elsewhere <= 1'b0;
      sb_held_off <= 1'b0;
    end else begin
      case (state)
        ST_BOOT: begin
          // wait for the settings, then apply the power-up choice
          if (wr_access && paddr == `REG_CONTROL) begin
            dc_output_on <= pwdata[`CTL_PWRUP_RESTORE] && retained_output_on; // [R11] [R12] [R19]
            enabled_elsewhere <= pwdata[`CTL_PWRUP_RESTORE] && retained_output_on;
            power_stage_on <= 1'b1;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (alarms.power_fail_alarm) begin
            dc_output_on <= 1'b0; // [R15]
            pre_alarm_on <= dc_output_on;
            state <= ST_PF_HOLD;
          end else if (alarms.overtemperature_alarm) begin
            power_stage_on <= 1'b0; // [R17]
            pre_alarm_on <= dc_output_on;
            dc_output_on <= 1'b0;
            state <= ST_OT_HOLD;
          end else if (trip_protect || cmd_off) begin
            dc_output_on <= 1'b0; // [R16]
            enabled_elsewhere <= 1'b0;
          end else if (sb_off_edge) begin
            dc_output_on <= 1'b0; // [R4] [R5]
            sb_held_off <= dc_output_on;
          end else if (cmd_on && !sb_active) begin
            dc_output_on <= 1'b1;
            power_stage_on <= 1'b1;
            enabled_elsewhere <= 1'b1;
          end else if (sb_on_edge && sb_held_off && enabled_elsewhere) begin
            dc_output_on <= 1'b1; // [R5]
            sb_held_off <= 1'b0;
          end
        end
        ST_OT_HOLD: begin
          if (!alarms.overtemperature_alarm && !alarms.power_fail_alarm) begin
            power_stage_on <= control[`CTL_OT_AUTO]; // [R9] [R10]
            dc_output_on <= control[`CTL_OT_AUTO] && pre_alarm_on; // [R9] [R10]
            enabled_elsewhere <= control[`CTL_OT_AUTO] && pre_alarm_on;
            state <= ST_RUN;
          end
        end
        ST_PF_HOLD: begin
          if (alarms.overtemperature_alarm)
            power_stage_on <= 1'b0; // [R17]
          if (!alarms.power_fail_alarm && !alarms.overtemperature_alarm) begin
            dc_output_on <= control[`CTL_PF_AUTO] && pre_alarm_on; // [R13] [R14]
            enabled_elsewhere <= control[`CTL_PF_AUTO] && pre_alarm_on;
            state <= ST_RUN;
          end
        end
        default: state <= ST_BOOT;
      endcase
    end
  end

  // ----------------------------------------
  // retained state, location and status pins
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      retained_output_store <= 1'b0;
      remote_active <= 1'b0;
      status_pins <= '0;
    end else begin
      retained_output_store <= (state == ST_RUN) ? dc_output_on : retained_output_on; // [R19]
      remote_active <= remote_ok; // [R2]
      status_pins.alarm_pin_1 <= (pin_select[`SEL_PIN1_OT] && alarms.overtemperature_alarm) ||
                                 (pin_select[`SEL_PIN1_PF] && alarms.power_fail_alarm); // [R6] [R18]
      status_pins.alarm_pin_2 <= (pin_select[`SEL_PIN2_OV] && alarms.overvoltage_alarm) ||
                                 (pin_select[`SEL_PIN2_OC] && alarms.overcurrent_alarm) ||
                                 (pin_select[`SEL_PIN2_OP] && alarms.overpower_alarm); // [R7] [R18]
      status_pins.status_pin_3 <= pin_select[`SEL_PIN3_DC] ? dc_output_on :
                                  alarms.constant_voltage_mode; // [R8]
    end
  end

  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------
  assign event_set = {sb_off_edge && state == ST_RUN, alarms.overpower_alarm,
                      alarms.overcurrent_alarm, alarms.overvoltage_alarm,
                      alarms.power_fail_alarm, alarms.overtemperature_alarm};
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      event_flags <= '0;
    end else if (wr_access && paddr == `REG_EVENT) begin
      event_flags <= (event_flags & ~pwdata[`EVT_WIDTH-1:0]) | event_set;
    end else begin
      event_flags <= event_flags | event_set;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_flags & event_mask);
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (rd_access) begin
      if (paddr == `REG_CONTROL) begin
        prdata <= control;
      end else if (paddr == `REG_PIN_SELECT) begin
        prdata <= pin_select;
      end else if (paddr == `REG_STATUS) begin
        prdata <= {24'h00_0000, state, remote_ok, power_stage_on, sb_active, dc_output_on};
      end else if (paddr == `REG_EVENT) begin
        prdata <= {26'h000_0000, event_flags};
      end else if (paddr == `REG_MASK) begin
        prdata <= {26'h000_0000, event_mask};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end
endmodule : output_state_alarm_signal_ctrl

// [shared/output_state_defines.svh]
// offsets, field positions and reset values of the output-state control block
`ifndef OUTPUT_STATE_DEFINES_SVH
`define OUTPUT_STATE_DEFINES_SVH
`define REG_CONTROL 12'h000
`define REG_PIN_SELECT 12'h004
`define REG_STATUS 12'h008
`define REG_EVENT 12'h00C
`define REG_MASK 12'h010
`define REG_COMMAND 12'h014
`define CTL_REMOTE_ALLOW 0
`define CTL_SB_INVERT 1
`define CTL_SB_AUTO 2
`define CTL_OT_AUTO 3
`define CTL_PWRUP_RESTORE 4
`define CTL_PF_AUTO 5
`define CTL_RESET 32'h0000_0000
`define SEL_PIN1_OT 0
`define SEL_PIN1_PF 1
`define SEL_PIN2_OV 2
`define SEL_PIN2_OC 3
`define SEL_PIN2_OP 4
`define SEL_PIN3_DC 5
`define SEL_RESET 32'h0000_0007
`define CMD_OUTPUT_ON 0
`define CMD_OUTPUT_OFF 1
`define EVT_OT 0
`define EVT_PF 1
`define EVT_OV 2
`define EVT_OC 3
`define EVT_OP 4
`define EVT_SB_OFF 5
`define EVT_WIDTH 6
`endif

// [shared/output_state_pkg.sv]
// types shared by the output-state control block
package output_state_pkg;
  typedef struct packed {
    logic overtemperature_alarm;
    logic power_fail_alarm;
    logic overvoltage_alarm;
    logic overcurrent_alarm;
    logic overpower_alarm;
    logic constant_voltage_mode;
  } alarm_in_t;
  typedef struct packed {
    logic alarm_pin_1;
    logic alarm_pin_2;
    logic status_pin_3;
  } status_pins_t;
  typedef enum logic [3:0] {
    ST_BOOT = 4'b0001,
    ST_RUN = 4'b0010,
    ST_OT_HOLD = 4'b0100,
    ST_PF_HOLD = 4'b1000
  } out_state_t;
endpackage : output_state_pkg

// [tb/far_side_model.sv]
// far side: standby and alarm sources, retained output cell
`timescale 1ns/1ps
module far_side_model (
  input wire logic sys_clk,
  input wire logic power_good,
  input wire logic sb_level,
  input wire logic [5:0] alarm_req,
  input wire logic retained_output_store,
  output output_state_pkg::alarm_in_t alarm_in,
  output logic remote_standby_input,
  output logic retained_output_on
);
  import output_state_pkg::*;
  logic powered;
  initial retained_output_on = 1'b0;
  initial powered = 1'b0;
  // cell ignores the first cycle of power: the store pin still shows its reset level
  always @(posedge sys_clk) begin
    remote_standby_input <= sb_level;
    alarm_in <= alarm_in_t'(alarm_req);
    powered <= power_good;
    if (power_good && powered)
      retained_output_on <= retained_output_store;
  end
endmodule : far_side_model

// [tb/out_ctrl_properties.sv]
// port assertions for the output-state control
`timescale 1ns/1ps
`include "output_state_defines.svh"
module out_ctrl_properties (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire output_state_pkg::alarm_in_t alarm_in,
  input wire logic dc_output_on,
  input wire logic power_stage_on,
  input wire logic irq,
  input wire output_state_pkg::status_pins_t status_pins
);
  import output_state_pkg::*;
  wire ot = alarm_in.overtemperature_alarm;
  wire pf = alarm_in.power_fail_alarm;
  wire trip = alarm_in.overvoltage_alarm | alarm_in.overcurrent_alarm | alarm_in.overpower_alarm;
  wire mapped = paddr == `REG_CONTROL || paddr == `REG_PIN_SELECT || paddr == `REG_STATUS ||
                paddr == `REG_EVENT || paddr == `REG_MASK || paddr == `REG_COMMAND;
  logic [3:0] quiet;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // cycles with both pin-1 alarms low
  always_ff @(posedge sys_clk) begin
    if (!reset_n || ot || pf)
      quiet <= 4'h0;
    else if (quiet != 4'hF)
      quiet <= quiet + 4'h1;
  end
  AST_SETUP_ANSWER: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  AST_ACCESS_ONLY: assert property (pready |-> psel && penable && !$past(penable))
    else $error("pready outside first access cycle");
  AST_UNMAPPED: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access without error");
  AST_MAPPED: assert property (pready && mapped |-> !pslverr)
    else $error("error on mapped access");
  AST_BOOT_OFF: assert property ($rose(reset_n) |-> !dc_output_on && !irq)
    else $error("outputs not off after reset");
  AST_PF_OFF: assert property ($rose(pf) |-> ##[1:8] !dc_output_on)
    else $error("power fail left output on");
  AST_PF_HOLD: assert property (pf [*8] |=> !dc_output_on)
    else $error("output on during power fail");
  AST_TRIP_OFF: assert property ($rose(trip) |-> ##[1:8] !dc_output_on)
    else $error("protection alarm left output on");
  AST_OT_STAGE: assert property ($rose(ot) |-> ##[1:8] !power_stage_on)
    else $error("overtemperature left stages on");
  AST_PIN1_IDLE: assert property (quiet >= 4'h8 |-> !status_pins.alarm_pin_1)
    else $error("pin 1 high with no alarm");
  COV_PF: cover property ($rose(pf));
  COV_ERR: cover property (pready && pslverr);
  COV_OFF: cover property ($fell(dc_output_on));
endmodule : out_ctrl_properties
bind output_state_alarm_signal_ctrl out_ctrl_properties props (.sys_clk(sys_clk),
  .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .alarm_in(alarm_in), .dc_output_on(dc_output_on),
  .power_stage_on(power_stage_on), .irq(irq), .status_pins(status_pins));

// [tb/tb_top.sv]
// bench for the output-state and alarm control
`timescale 1ns/1ps
`include "output_state_defines.svh"
module tb_top;
  import output_state_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic sb = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] alarm_req = 6'h00;
  logic [15:0] lfsr = 16'hD173;
  logic [31:0] prdata;
  logic pready, pslverr, sb_pin, ret_on, ret_st, dc_on, stage_on, remote, irq;
  alarm_in_t alarms;
  status_pins_t pins;
  logic [31:0] exp_q[$];
  int n_mismatch = 0;
  int checks_done = 0;
  always #10 sys_clk = ~sys_clk;
  output_state_alarm_signal_ctrl DUT (.sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarm_in(alarms), .remote_standby_input(sb_pin),
    .retained_output_on(ret_on), .retained_output_store(ret_st), .dc_output_on(dc_on),
    .power_stage_on(stage_on), .remote_active(remote), .status_pins(pins), .irq(irq));
  far_side_model far (.sys_clk(sys_clk), .power_good(reset_n), .sb_level(sb),
    .alarm_req(alarm_req), .retained_output_store(ret_st), .alarm_in(alarms),
    .remote_standby_input(sb_pin), .retained_output_on(ret_on));
  function automatic logic [15:0] next_rand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : next_rand
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask : rd
  // e[1] picks stage or output, e[0] the level expected
  task automatic step(input logic s, input logic [5:0] a, input logic [1:0] e);
    sb <= s;
    alarm_req <= a;
    repeat (8) @(posedge sys_clk);
    if (e[1])
      cmp("power_stage_on", e[0], stage_on);
    else
      cmp("dc_output_on", e[0], dc_on);
  endtask : step
  // switch the output on, cut power, then boot with the given settings
  task automatic power_cycle(input logic [31:0] ctl, input logic [1:0] e);
    apb(`REG_COMMAND, 1'b1, 32'h1);
    step(0, 6'h00, 2'b01);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    apb(`REG_CONTROL, 1'b1, ctl);
    step(0, 6'h00, e);
  endtask : power_cycle
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  always @(posedge sys_clk) begin
    if (psel && penable && !pwrite && pready === 1'b1)
      cmp("prdata", exp_q.pop_front(), prdata);
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(`REG_CONTROL, `CTL_RESET);
    rd(`REG_PIN_SELECT, `SEL_RESET);
    rd(12'h020, 32'h0);
    apb(`REG_CONTROL, 1'b1, 32'h0);
    apb(`REG_COMMAND, 1'b1, 32'h1);
    step(0, 6'h00, 2'b00);
    cmp("remote_active", 0, remote);
    apb(`REG_CONTROL, 1'b1, 32'h1);
    apb(`REG_COMMAND, 1'b1, 32'h1);
    step(0, 6'h00, 2'b01);
    cmp("remote_active", 1, remote);
    rd(`REG_STATUS, 32'h2D);
    $display("remote test done");
    apb(`REG_CONTROL, 1'b1, 32'h7);
    step(0, 6'h00, 2'b00);
    step(1, 6'h00, 2'b01);
    apb(`REG_CONTROL, 1'b1, 32'h5);
    step(1, 6'h00, 2'b00);
    step(0, 6'h00, 2'b01);
    apb(`REG_CONTROL, 1'b1, 32'h1);
    step(1, 6'h00, 2'b00);
    step(0, 6'h00, 2'b00);
    $display("standby test done");
    apb(`REG_CONTROL, 1'b1, 32'h21);
    apb(`REG_COMMAND, 1'b1, 32'h1);
    step(0, 6'h10, 2'b00);
    step(0, 6'h00, 2'b01);
    apb(`REG_CONTROL, 1'b1, 32'h1);
    step(0, 6'h10, 2'b00);
    step(0, 6'h00, 2'b00);
    apb(`REG_CONTROL, 1'b1, 32'h21);
    step(0, 6'h10, 2'b00);
    step(0, 6'h00, 2'b00);
    for (int i = 1; i < 4; i++) begin
      apb(`REG_COMMAND, 1'b1, 32'h1);
      step(0, 6'h01 << i, 2'b00);
      step(0, 6'h00, 2'b00);
    end
    apb(`REG_CONTROL, 1'b1, 32'h9);
    apb(`REG_COMMAND, 1'b1, 32'h1);
    step(0, 6'h20, 2'b10);
    step(0, 6'h00, 2'b11);
    apb(`REG_CONTROL, 1'b1, 32'h1);
    step(0, 6'h20, 2'b10);
    step(0, 6'h00, 2'b10);
    $display("alarm test done");
    apb(`REG_COMMAND, 1'b1, 32'h2);
    for (int i = 0; i < 8; i++) begin
      lfsr = next_rand(lfsr);
      apb(`REG_PIN_SELECT, 1'b1, {26'h0, lfsr[5:0]});
      step(0, lfsr[11:6], 2'b00);
      cmp("pin1", lfsr[11] & lfsr[0] | lfsr[10] & lfsr[1], pins.alarm_pin_1);
      cmp("pin2", |(lfsr[9:7] & {lfsr[2], lfsr[3], lfsr[4]}), pins.alarm_pin_2);
      cmp("pin3", !lfsr[5] & lfsr[6], pins.status_pin_3);
    end
    $display("pin test done");
    apb(`REG_MASK, 1'b1, 32'h4);
    step(0, 6'h00, 2'b00);
    apb(`REG_EVENT, 1'b1, 32'h3F);
    step(0, 6'h08, 2'b00);
    cmp("irq", 1, irq);
    apb(`REG_EVENT, 1'b1, 32'h4);
    step(0, 6'h08, 2'b00);
    cmp("irq", 1, irq);
    step(0, 6'h00, 2'b00);
    apb(`REG_EVENT, 1'b1, 32'h4);
    step(0, 6'h00, 2'b00);
    cmp("irq", 0, irq);
    apb(`REG_MASK, 1'b1, 32'h0);
    step(0, 6'h08, 2'b00);
    cmp("irq", 0, irq);
    rd(`REG_EVENT, 32'h4);
    step(0, 6'h00, 2'b00);
    $display("irq test done");
    power_cycle(32'h1, 2'b00);
    power_cycle(32'h11, 2'b01);
    cmp("retained", 1, ret_on);
    $display("reset test done");
    finish_test();
  end
  // all tests need well under ten thousand cycles
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
endmodule : tb_top
